/* include/dout_select_defines.svh */
// Purpose: Offsets, field positions, codes and reset values for the output select
// Assumes: Wishbone byte addresses, 32-bit data
// Notes: Definitions only
`ifndef DOUT_SELECT_DEFINES_SVH
`define DOUT_SELECT_DEFINES_SVH
`define FUNC_DISABLED 8'h00
`define FUNC_CAPTURE_DONE 8'h16
`define FUNC_MOTION_DONE 8'h17
`define FUNC_CAM_AREA 8'h18
`define FUNC_SPEED_REACHED 8'h19
`define FUNC_ZONE_ONE 8'h1A
`define FUNC_SDO_FIRST 8'h30
`define FUNC_SDO_LAST 8'h37
`define NUM_OUTPUTS 5
`define REG_FUNC_BASE 8'h00
`define REG_SW_WORD 8'h14
`define REG_SPEED_THRESH 8'h18
`define REG_ZONE_LOWER 8'h1C
`define REG_ZONE_UPPER 8'h20
`define REG_ABS_DATA 8'h24
`define REG_STATUS 8'h28
`define REG_CONTROL 8'h2C
`define CTRL_ABS_NEXT_BIT 0
`define RESET_FUNC 8'h00
`define RESET_WORD 16'h0000
`endif

/* include/dout_select_pkg.sv */
// Purpose: Types shared by the output select block
// Assumes: Constants live in the defines header
// Notes: None
package dout_select_pkg;
   typedef logic [7:0] func_code_t;
   typedef struct packed {
      logic capture_done;
      logic command_done;
      logic in_position_status;
      logic cam_in_area;
      logic position_register_mode;
      logic speed_mode;
   } drive_status_s;
   typedef enum logic [1:0] {
      ABS_IDLE = 2'b00,
      ABS_PRESENT = 2'b01,
      ABS_FETCHED = 2'b11
   } abs_state_e;
endpackage : dout_select_pkg

/* src/func_code_store.sv */
// Purpose: Small register memory holding one function code per output
// Assumes: Single clock, synchronous active-high reset
// Notes: Read data registered
`timescale 1ns/100ps
`default_nettype none
`include "dout_select_defines.svh"
module func_code_store
   import dout_select_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [2:0] wr_index,
   input wire logic [7:0] wr_data,
   input wire logic [2:0] rd_index,
   output logic [7:0] rd_data,
   output logic [`NUM_OUTPUTS*8-1:0] all_codes
);
   logic [7:0] mem [`NUM_OUTPUTS];
   genvar g;
   generate
      for (g = 0; g < `NUM_OUTPUTS; g++) begin : g_entry
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               mem[g] <= `RESET_FUNC;
            end else if (wr_en && wr_index == 3'(g)) begin
               mem[g] <= wr_data;
            end
         end
         assign all_codes[g*8 +: 8] = mem[g];
      end
   endgenerate
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rd_data <= 8'h00;
      end else if (rd_index < 3'(`NUM_OUTPUTS)) begin
         rd_data <= mem[rd_index];
      end else begin
         rd_data <= 8'h00;
      end
   end
endmodule : func_code_store
`default_nettype wire

/* src/digital_output_function_select.sv */
// Purpose: Drives configurable digital outputs from selected drive status
// Assumes: Status inputs come from drive logic on ref_clk; absolute enable is a pin
// Notes: Registers on classic Wishbone
//
// The register addresses and the Wishbone interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "dout_select_defines.svh"
module digital_output_function_select
   import dout_select_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o,
   output logic wb_err_o,
   input wire drive_status_s status_in,
   input wire logic position_command_busy,
   input wire logic [15:0] speed_error,
   input wire logic [31:0] monitored_value,
   input wire logic absolute_mode_enable,
   output logic [`NUM_OUTPUTS-1:0] output_pins,
   output logic output_pin_two,
   output logic output_pin_three
);
   logic abs_en_meta;
   logic abs_en;
   logic [15:0] software_output_word;
   logic [15:0] speed_reached_threshold;
   logic [31:0] zone_lower_limit;
   logic [31:0] zone_upper_limit;
   logic [31:0] abs_shift;
   logic [4:0] abs_bit_count;
   logic abs_handshake_ready;
   logic abs_serial_data;
   abs_state_e abs_state;
   abs_state_e next_abs_state;
   logic [`NUM_OUTPUTS*8-1:0] all_codes;
   logic [7:0] code_rd_data;
   logic req;
   logic hit_code;
   logic hit_reg;
   logic rd_code_pending;
   logic [31:0] reg_rd;
   logic next_bit_req;
   logic motion_done_out;
   logic speed_reached_out;
   logic zone_one_out;
   logic [`NUM_OUTPUTS-1:0] func_out;

   // Absolute enable pin synchroniser
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         abs_en_meta <= 1'b0;
         abs_en <= 1'b0;
      end else begin
         abs_en_meta <= absolute_mode_enable;
         abs_en <= abs_en_meta;
      end
   end

   // Bus decode
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   always_comb begin
      hit_code = 1'b0;
      hit_reg = 1'b0;
      if (wb_adr_i[31:8] != 24'h000000 || wb_adr_i[1:0] != 2'b00) begin
         hit_reg = 1'b0;
      end else if (wb_adr_i[7:0] < `REG_SW_WORD) begin
         hit_code = 1'b1;
      end else if (wb_adr_i[7:0] <= `REG_CONTROL) begin
         hit_reg = 1'b1;
      end
   end

   func_code_store u_codes (
      .ref_clk(ref_clk),
      .rst(rst),
      .wr_en(req && hit_code && wb_we_i && wb_sel_i[0]),
      .wr_index(wb_adr_i[4:2]),
      .wr_data(wb_dat_i[7:0]),
      .rd_index(wb_adr_i[4:2]),
      .rd_data(code_rd_data),
      .all_codes(all_codes)
   );

   // Register writes
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         software_output_word <= `RESET_WORD;
         speed_reached_threshold <= `RESET_WORD;
         zone_lower_limit <= 32'h00000000;
         zone_upper_limit <= 32'h00000000;
      end else if (req && hit_reg && wb_we_i) begin
         if (wb_adr_i[7:0] == `REG_SW_WORD) begin
            if (wb_sel_i[0]) software_output_word[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) software_output_word[15:8] <= wb_dat_i[15:8];
         end else if (wb_adr_i[7:0] == `REG_SPEED_THRESH) begin
            if (wb_sel_i[0]) speed_reached_threshold[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) speed_reached_threshold[15:8] <= wb_dat_i[15:8];
         end else if (wb_adr_i[7:0] == `REG_ZONE_LOWER) begin
            for (int b = 0; b < 4; b++) begin
               if (wb_sel_i[b]) zone_lower_limit[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            end
         end else if (wb_adr_i[7:0] == `REG_ZONE_UPPER) begin
            for (int b = 0; b < 4; b++) begin
               if (wb_sel_i[b]) zone_upper_limit[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            end
         end
      end
   end

   assign next_bit_req = req && hit_reg && wb_we_i && wb_sel_i[0]
      && wb_adr_i[7:0] == `REG_CONTROL && wb_dat_i[`CTRL_ABS_NEXT_BIT];

   // Register read mux
   always_comb begin
      reg_rd = 32'h00000000;
      if (wb_adr_i[7:0] == `REG_SW_WORD) begin
         reg_rd = {16'h0000, software_output_word};
      end else if (wb_adr_i[7:0] == `REG_SPEED_THRESH) begin
         reg_rd = {16'h0000, speed_reached_threshold};
      end else if (wb_adr_i[7:0] == `REG_ZONE_LOWER) begin
         reg_rd = zone_lower_limit;
      end else if (wb_adr_i[7:0] == `REG_ZONE_UPPER) begin
         reg_rd = zone_upper_limit;
      end else if (wb_adr_i[7:0] == `REG_STATUS) begin
         reg_rd = {22'h000000, abs_bit_count, abs_en, abs_handshake_ready,
            abs_serial_data, motion_done_out, speed_reached_out};
      end
   end

   // Bus answer, code reads take a second cycle for the memory
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         rd_code_pending <= 1'b0;
      end else begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         rd_code_pending <= 1'b0;
         if (rd_code_pending) begin
            wb_ack_o <= 1'b1;
            wb_dat_o <= {24'h000000, code_rd_data};
         end else if (req && hit_code && !wb_we_i) begin
            rd_code_pending <= 1'b1;
         end else if (req && (hit_code || hit_reg)) begin
            wb_ack_o <= 1'b1;
            wb_dat_o <= wb_we_i ? 32'h00000000 : reg_rd;
         end else if (req) begin
            wb_err_o <= 1'b1;
            wb_dat_o <= 32'h00000000;
         end
      end
   end

   // Absolute position serial handshake
   always_comb begin
      next_abs_state = abs_state;
      case (abs_state)
         ABS_IDLE: if (abs_en) next_abs_state = ABS_PRESENT;
         ABS_PRESENT: if (next_bit_req) next_abs_state = ABS_FETCHED;
         ABS_FETCHED: if (next_bit_req) next_abs_state = ABS_PRESENT;
         default: next_abs_state = ABS_IDLE;
      endcase
      if (!abs_en) next_abs_state = ABS_IDLE;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         abs_state <= ABS_IDLE;
         abs_shift <= 32'h00000000;
         abs_bit_count <= 5'h00;
      end else begin
         abs_state <= next_abs_state;
         if (req && hit_reg && wb_we_i && wb_adr_i[7:0] == `REG_ABS_DATA) begin
            abs_shift <= wb_dat_i;
            abs_bit_count <= 5'h00;
         end else if (abs_state == ABS_FETCHED && next_bit_req) begin
            abs_shift <= {1'b0, abs_shift[31:1]};
            abs_bit_count <= abs_bit_count + 5'h01;
         end
      end
   end

   assign abs_handshake_ready = (abs_state == ABS_FETCHED);
   assign abs_serial_data = abs_shift[0];

   // Per-status levels
   assign motion_done_out = status_in.command_done && !position_command_busy
      && status_in.in_position_status;
   assign speed_reached_out = status_in.speed_mode
      && speed_error <= speed_reached_threshold;
   assign zone_one_out = monitored_value >= zone_lower_limit
      && monitored_value <= zone_upper_limit;

   // Per-output function selection
   genvar g;
   generate
      for (g = 0; g < `NUM_OUTPUTS; g++) begin : g_pin
         always_comb begin
            func_out[g] = 1'b0;
            case (all_codes[g*8 +: 8])
               `FUNC_CAPTURE_DONE:
                  func_out[g] = status_in.capture_done && status_in.position_register_mode;
               `FUNC_MOTION_DONE: func_out[g] = motion_done_out;
               `FUNC_CAM_AREA:
                  func_out[g] = status_in.cam_in_area && status_in.position_register_mode;
               `FUNC_SPEED_REACHED: func_out[g] = speed_reached_out;
               `FUNC_ZONE_ONE: func_out[g] = zone_one_out;
               default: begin
                  if (all_codes[g*8 +: 8] >= `FUNC_SDO_FIRST
                     && all_codes[g*8 +: 8] <= `FUNC_SDO_LAST) begin
                     func_out[g] = software_output_word[all_codes[g*8 +: 3]];
                  end
               end
            endcase
         end
      end
   endgenerate

   // Registered levels onto the pins
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         output_pins <= '0;
         output_pin_two <= 1'b0;
         output_pin_three <= 1'b0;
      end else begin
         output_pins <= func_out;
         output_pin_two <= abs_en ? abs_handshake_ready : func_out[2];
         output_pin_three <= abs_en ? abs_serial_data : func_out[3];
      end
   end
endmodule : digital_output_function_select
`default_nettype wire

/* testbench/dout_select_checker.sv */
// Purpose: Port-level assertions for the output select
// Assumes: Single clock, synchronous active-high reset
// Notes: Bound to the top module below
`timescale 1ns/100ps
`default_nettype none
`include "dout_select_defines.svh"
module dout_select_checker
   import dout_select_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   input wire logic absolute_mode_enable,
   input wire logic [`NUM_OUTPUTS-1:0] output_pins,
   input wire logic output_pin_two,
   input wire logic output_pin_three
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   sequence abs_quiet;
      absolute_mode_enable && !wb_cyc_i;
   endsequence
   sequence abs_off;
      !absolute_mode_enable [*6];
   endsequence
   AST_ACK_PULSE:
      assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   AST_ERR_PULSE:
      assert property (wb_err_o |=> !wb_err_o) else $error("err too long");
   AST_ACK_CAUSE:
      assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
   AST_ANSWER_BOUND:
      assert property ($rose(wb_stb_i) |-> ##[1:2] (wb_ack_o || wb_err_o))
      else $error("no bus answer");
   AST_RESET_ZERO:
      assert property ($fell(rst) |-> output_pins == '0 && !output_pin_two && !output_pin_three)
      else $error("outputs active after reset");
   AST_PIN_TWO_FOLLOW:
      assert property (abs_off |-> output_pin_two == output_pins[2])
      else $error("pin two not on function");
   AST_PIN_THREE_FOLLOW:
      assert property (abs_off |-> output_pin_three == output_pins[3])
      else $error("pin three not on function");
   AST_ABS_READY_LOW:
      assert property ($rose(absolute_mode_enable) ##1 abs_quiet [*6] |-> !output_pin_two)
      else $error("ready not low at start");
endmodule : dout_select_checker
bind digital_output_function_select dout_select_checker u_chk (.ref_clk, .rst, .wb_cyc_i,
   .wb_stb_i, .wb_ack_o, .wb_err_o, .absolute_mode_enable, .output_pins, .output_pin_two,
   .output_pin_three);
`default_nettype wire

/* testbench/host_abs_reader.sv */
// Purpose: Host controller model reading absolute bits
// Assumes: Host owns the enable it watches
// Notes: Bits collected lowest first
`timescale 1ns/100ps
`default_nettype none
module host_abs_reader (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic abs_en,
   input wire logic ready,
   input wire logic data,
   output logic [31:0] word,
   output logic [5:0] count
);
   logic ready_q;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ready_q <= 1'b0;
         word <= 32'h0;
         count <= 6'h0;
      end else begin
         ready_q <= ready;
         if (abs_en && ready && !ready_q) begin
            word[count[4:0]] <= data;
            count <= count + 6'h1;
         end
      end
   end
endmodule : host_abs_reader
`default_nettype wire

/* testbench/tb.sv */
// Purpose: Self-checking bench for the output select
// Assumes: Host model collects absolute bits
// Notes: Random stimulus with fixed seed
`timescale 1ns/100ps
`default_nettype none
`include "dout_select_defines.svh"
module tb
   import dout_select_pkg::*;
;
   logic ref_clk, rst = 1, we = 0, cyc = 0, stb = 0, abs_en = 0, busy = 0, err_seen;
   logic [31:0] adr = 0, wdat = 0, mon = 0, rdat, wb_dat_o, lo, hi, d, hw;
   logic [15:0] serr = 0, sw, thr;
   logic [7:0] c;
   logic [3:0] sel = 4'hF, bsel = 4'hF;
   logic [5:0] hn;
   logic [`NUM_OUTPUTS-1:0] pins;
   logic ack, err, p2, p3;
   drive_status_s st = '0;
   int fail_count = 0, n_tests = 0, k;
   digital_output_function_select dut (.ref_clk, .rst, .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_dat_o, .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_ack_o(ack), .wb_err_o(err), .status_in(st), .position_command_busy(busy),
      .speed_error(serr), .monitored_value(mon), .absolute_mode_enable(abs_en),
      .output_pins(pins), .output_pin_two(p2), .output_pin_three(p3));
   host_abs_reader host (.ref_clk, .rst, .abs_en, .ready(p2), .data(p3), .word(hw), .count(hn));
   task automatic final_report;
      $display("checks=%0d mismatches=%0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] v);
      int i;
      i = 0;
      @(posedge ref_clk);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      wdat <= v;
      sel <= bsel;
      do begin
         @(posedge ref_clk);
         i++;
      end while (ack !== 1'b1 && err !== 1'b1 && i < 20);
      rdat = wb_dat_o;
      err_seen = err;
      cyc <= 0;
      stb <= 0;
      we <= 0;
      if (ack !== 1'b1 && err !== 1'b1) begin
         fail_count++;
         final_report();
      end
   endtask : bus
   task automatic settle;
      repeat (3) @(posedge ref_clk);
   endtask : settle
   function automatic logic fexp(input logic [7:0] f);
      case (f)
         8'h16: return st.capture_done & st.position_register_mode;
         8'h17: return st.command_done & st.in_position_status & !busy;
         8'h18: return st.cam_in_area & st.position_register_mode;
         8'h19: return st.speed_mode & (serr <= thr);
         8'h1A: return (mon >= lo) & (mon <= hi);
         default: return (f[7:3] == 5'h06) ? sw[f[2:0]] : 1'b0;
      endcase
   endfunction : fexp
   initial begin
      ref_clk = 0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      void'($urandom(32'h90F8));
      repeat (2) @(posedge ref_clk);
      rst <= 0;
      for (k = 0; k < 6; k++) begin
         bus(0, k * 4, 0);
         chk(rdat, 0);
      end
      bus(0, 32'h30, 0);
      chk(err_seen, 1);
      chk(pins, 0);
      $display("reset test done");
      thr = 16'h1000 + $urandom % 256;
      lo = 100 + $urandom % 50;
      hi = lo + 20;
      bus(1, 32'h18, thr);
      bus(1, 32'h1C, lo);
      bus(1, 32'h20, hi);
      bus(0, 32'h18, 0);
      chk(rdat, {16'h0000, thr});
      bus(0, 32'h1C, 0);
      chk(rdat, lo);
      bus(0, 32'h20, 0);
      chk(rdat, hi);
      // Byte lane one only
      bsel = 4'h2;
      bus(1, 32'h1C, 32'hFFFFFFFF);
      bsel = 4'hF;
      bus(0, 32'h1C, 0);
      chk(rdat, (lo & 32'hFFFF00FF) | 32'h0000FF00);
      bus(1, 32'h1C, lo);
      for (k = 0; k < 56; k++) begin
         c = (k % 14 == 0) ? 8'h00 : (k % 14 < 6) ? 8'h15 + k % 14 : 8'h2A + k % 14;
         sw = $urandom;
         st <= 6'($urandom);
         busy <= ($urandom % 4 == 0);
         serr <= thr - 2 + $urandom % 5;
         mon <= lo - 2 + $urandom % 25;
         bus(1, 32'h14, sw);
         bus(1, (k % 5) * 4, c);
         bus(0, (k % 5) * 4, 0);
         chk(rdat, {24'h000000, c});
         settle();
         chk(pins[k % 5], fexp(c));
      end
      $display("function test done");
      sw = 16'h0001;
      bus(1, 32'h14, sw);
      bus(1, 32'h08, 8'h30);
      d = $urandom;
      bus(1, 32'h24, d);
      settle();
      chk(p2, 1);
      abs_en <= 1;
      settle();
      settle();
      chk(p2, 0);
      chk(p3, d[0]);
      for (k = 0; k < 8; k++) begin
         bus(1, 32'h2C, 1);
         settle();
         chk(p2, 1);
         chk(p3, d[k]);
         bus(1, 32'h2C, 1);
         settle();
         chk(p2, 0);
      end
      chk({hn, hw[7:0]}, {6'h08, d[7:0]});
      bus(0, 32'h28, 0);
      chk(rdat[9:2], {5'h08, 1'b1, 1'b0, d[8]});
      abs_en <= 0;
      settle();
      settle();
      chk(p2, 1);
      $display("absolute test done");
      final_report();
   end
endmodule : tb
`default_nettype wire
